// *** ipx_carrier.sv ***
// carrier board model: master of the ip module logic bus
// assumes the engine answers with ack_n low one cycle after taking
`default_nettype none
module ipx_carrier
   import ipx_pkg::*;
(
   // clock
   input wire logic clk,
   // selects and controls
   output logic io_sel_n,
   output logic id_sel_n,
   output logic mem_sel_n,
   output logic int_sel_n,
   output logic dma_ack_n,
   output logic rw_n,
   output logic be0_n,
   output logic be1_n,
   output logic hold,
   output logic [ADDR_W:1] addr,
   // host data bus
   output logic [DATA_W-1:0] host_data_in,
   input wire logic ack_n,
   input wire logic [DATA_W-1:0] host_data_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {io_sel_n, id_sel_n, mem_sel_n, int_sel_n, dma_ack_n} = 5'h1f;
      {rw_n, be0_n, be1_n, hold} = 4'h8;
      addr = 6'h00;
      host_data_in = 16'h0000;
   end

   // ---------------------------------------------------------------
   // one bus cycle; kind 0 io, 1 id, 2 mem, 3 int, 4 dma
   // ---------------------------------------------------------------
   // lat 0 means no ack within eight cycles
   task automatic cyc(input int kind, input logic rw,
      input logic [1:0] be, input logic [5:0] a, input logic [15:0] d,
      input int h, output int lat, output logic [15:0] rd);
      lat = 0;
      rd = 16'h0000;
      @(posedge clk);
      io_sel_n <= (kind != 0);
      id_sel_n <= (kind != 1);
      mem_sel_n <= (kind != 2);
      int_sel_n <= (kind != 3);
      dma_ack_n <= (kind != 4);
      rw_n <= rw;
      // byte lanes as the caller asks
      {be1_n, be0_n} <= be;
      addr <= a;
      host_data_in <= rw ? ~d : d;
      hold <= (h > 0);
      for (int i = 1; i <= 8 && lat == 0; i++) begin
         @(posedge clk);
         if (i == h) hold <= 1'b0;
         @(negedge clk);
         if (ack_n === 1'b0) begin
            lat = i;
            rd = host_data_out;
         end
      end
      @(posedge clk);
      {io_sel_n, id_sel_n, mem_sel_n, int_sel_n, dma_ack_n} <= 5'h1f;
      hold <= 1'b0;
      // released bus must not keep the old word
      host_data_in <= ~d;
      @(negedge clk);
   endtask
endmodule
`default_nettype wire

// *** ipx_conv_bank.sv ***
// converter bank: two quad converters, double-buffered codes
// assumes strobes from the engine, one cycle wide
`default_nettype none
module ipx_conv_bank
   import ipx_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // engine side
   ipx_conv_if.bank cv,
   // analog side codes
   output logic [CHAN_N*CODE_W-1:0] dac_code
);
   // ---------------------------------------------------------------
   // per channel input and output registers
   // ---------------------------------------------------------------
   logic [CODE_W-1:0] in_q [CHAN_N];
   logic [CODE_W-1:0] in_d [CHAN_N];
   logic [CODE_W-1:0] out_q [CHAN_N];
   logic [CODE_W-1:0] out_d [CHAN_N];
   genvar g;
   generate
      for (g = 0; g < CHAN_N; g++) begin : g_ch
         localparam logic [1:0] CH = 2'(g % 4);
         localparam int BK = g / 4;
         always_comb begin
            in_d[g] = in_q[g];
            if (cv.wr && cv.cs[BK] && cv.chan == CH) begin
               in_d[g] = cv.wdata[CODE_W-1:0];
            end
            // second stage follows first one cycle later
            out_d[g] = in_q[g];
         end
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               in_q[g] <= MID_CODE;
               out_q[g] <= MID_CODE;
            end else if (ce) begin
               in_q[g] <= in_d[g];
               out_q[g] <= out_d[g];
            end
         end
         assign dac_code[g*CODE_W +: CODE_W] = out_q[g];
      end
   endgenerate
   always_comb begin
      cv.rdata = 12'h000;
      // gated so only a read cycle puts a code on the bus
      if (cv.rd) begin
         cv.rdata = in_q[{cv.cs[1], cv.chan}];
      end
   end
endmodule
`default_nettype wire

// *** ipx_conv_if.sv ***
// interface from the engine to the converter bank
// assumes one clock domain
`default_nettype none
interface ipx_conv_if;
   logic [1:0] cs;
   logic wr;
   logic rd;
   logic [1:0] chan;
   logic [15:0] wdata;
   logic [11:0] rdata;
   modport eng (output cs, output wr, output rd, output chan,
      output wdata, input rdata);
   modport bank (input cs, input wr, input rd, input chan,
      input wdata, output rdata);
endinterface
`default_nettype wire

// *** ipx_engine.sv ***
// ip module transfer engine for an eight channel converter module
// assumes carrier is bus master; strobes synchronous to clk
`default_nettype none
module ipx_engine
   import ipx_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // ip bus selects and controls
   input wire logic io_sel_n,
   input wire logic id_sel_n,
   input wire logic mem_sel_n,
   input wire logic int_sel_n,
   input wire logic dma_ack_n,
   input wire logic rw_n,
   input wire logic be0_n,
   input wire logic be1_n,
   input wire logic hold,
   input wire logic [ADDR_W:1] addr,
   // host data bus
   input wire logic [DATA_W-1:0] host_data_in,
   output logic [DATA_W-1:0] host_data_out,
   output logic host_data_oe,
   output logic ack_n,
   output logic int_req0_n,
   output logic int_req1_n,
   output logic dma_req_n,
   // transceiver and converter strobes
   output logic xcvr_oe_n,
   output logic xcvr_dir_h2c,
   output logic first_quad_converter_cs_n,
   output logic second_quad_converter_cs_n,
   output logic conv_wr_n,
   output logic conv_rd_n,
   // analog codes
   output logic [CHAN_N*CODE_W-1:0] dac_code
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {S_IDLE, S_DONE} ipx_state_t;
   ipx_state_t st_q, st_d;
   logic [5:0] a6;
   logic io_hit, id_hit, word_xfer;
   logic ack_n_q, ack_n_d, oe_q, oe_d;
   logic xoe_n_q, xoe_n_d, dir_q, dir_d;
   logic cs1_n_q, cs1_n_d, cs2_n_q, cs2_n_d;
   logic wr_n_q, wr_n_d, rd_n_q, rd_n_d;
   logic [15:0] dout_q, dout_d;
   logic [15:0] id_word;
   ipx_conv_if cv();
   // addr is already a word address, so no byte bit sits below it
   assign a6 = addr;
   assign io_hit = !io_sel_n && ((a6 & IO_MASK) == IO_BASE);
   assign id_hit = !id_sel_n && ((a6 & ID_MASK) == ID_BASE);
   // both lanes enabled means a word
   assign word_xfer = !be0_n && !be1_n;
   ipx_id_rom u_rom (
      .idx(addr[5:1]),
      .word(id_word)
   );
   ipx_conv_bank u_bank (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .cv(cv),
      .dac_code(dac_code)
   );
   assign cv.cs = io_hit ? (addr[3] ? 2'b10 : 2'b01) : 2'b00;
   assign cv.chan = addr[2:1];
   assign cv.wdata = host_data_in;
   assign cv.wr = (st_q == S_IDLE) && io_hit && !rw_n && word_xfer
      && !hold;
   assign cv.rd = (st_q == S_IDLE) && io_hit && rw_n && !hold;
   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      // defaults leave a miss fully idle
      st_d = st_q;
      ack_n_d = 1'b1;
      oe_d = 1'b0;
      xoe_n_d = 1'b1;
      dir_d = 1'b0;
      cs1_n_d = 1'b1;
      cs2_n_d = 1'b1;
      wr_n_d = 1'b1;
      rd_n_d = 1'b1;
      dout_d = 16'h0000;
      unique case (st_q)
         S_IDLE: begin
            if (!hold && (io_hit || id_hit)) begin
               ack_n_d = 1'b0;
               st_d = S_DONE;
               if (id_hit) begin
                  oe_d = rw_n;
                  dout_d = id_word;
               end else begin
                  xoe_n_d = !(rw_n || word_xfer);
                  dir_d = !rw_n;
                  oe_d = rw_n;
                  cs1_n_d = !cv.cs[0];
                  cs2_n_d = !cv.cs[1];
                  wr_n_d = !cv.wr;
                  rd_n_d = !cv.rd;
                  dout_d = {4'h0, cv.rdata};
               end
            end
         end
         S_DONE: begin
            // everything released the cycle after ack
            // waiting for both selects high stops a double ack
            if (io_sel_n && id_sel_n) begin
               st_d = S_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= S_IDLE;
         ack_n_q <= 1'b1;
         oe_q <= 1'b0;
         xoe_n_q <= 1'b1;
         dir_q <= 1'b0;
         cs1_n_q <= 1'b1;
         cs2_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         dout_q <= 16'h0000;
      end else if (ce) begin
         st_q <= st_d;
         ack_n_q <= ack_n_d;
         oe_q <= oe_d;
         xoe_n_q <= xoe_n_d;
         dir_q <= dir_d;
         cs1_n_q <= cs1_n_d;
         cs2_n_q <= cs2_n_d;
         wr_n_q <= wr_n_d;
         rd_n_q <= rd_n_d;
         dout_q <= dout_d;
      end
   end
   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign ack_n = ack_n_q;
   assign host_data_oe = oe_q;
   assign host_data_out = dout_q;
   assign xcvr_oe_n = xoe_n_q;
   assign xcvr_dir_h2c = dir_q;
   assign first_quad_converter_cs_n = cs1_n_q;
   assign second_quad_converter_cs_n = cs2_n_q;
   assign conv_wr_n = wr_n_q;
   assign conv_rd_n = rd_n_q;
   // request lines tied inactive, selects ignored
   assign int_req0_n = 1'b1;
   assign int_req1_n = 1'b1;
   assign dma_req_n = 1'b1;
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_no_irq;
      @(posedge clk) disable iff (!resetn)
         int_req0_n && int_req1_n && dma_req_n;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("request raised");
   property p_mem_ign;
      @(posedge clk) disable iff (!resetn)
         (ce && st_q == S_IDLE && !mem_sel_n && io_sel_n && id_sel_n)
         |=> ack_n;
   endproperty
   a_mem_ign: assert property (p_mem_ign) else $error("mem acked");
   property p_id_ack;
      @(posedge clk) disable iff (!resetn)
         (ce && st_q == S_IDLE && id_hit && !hold) |=> !ack_n
         && (oe_q == $past(rw_n));
   endproperty
   a_id_ack: assert property (p_id_ack) else $error("id ack late");
   property p_io_ack;
      @(posedge clk) disable iff (!resetn)
         (ce && st_q == S_IDLE && io_hit && !hold) |=> !ack_n;
   endproperty
   a_io_ack: assert property (p_io_ack) else $error("io ack late");
   property p_hold;
      @(posedge clk) disable iff (!resetn)
         (ce && st_q == S_IDLE && hold) |=> ack_n && conv_wr_n;
   endproperty
   a_hold: assert property (p_hold) else $error("ack in hold");
   property p_byte;
      @(posedge clk) disable iff (!resetn)
         (ce && !word_xfer) |=> conv_wr_n;
   endproperty
   a_byte: assert property (p_byte) else $error("byte write strobe");
   property p_bank;
      @(posedge clk) disable iff (!resetn)
         (ce && cv.cs != 2'b00 && st_q == S_IDLE && !hold)
         |=> (first_quad_converter_cs_n == $past(addr[3]))
         && (second_quad_converter_cs_n == !$past(addr[3]));
   endproperty
   a_bank: assert property (p_bank) else $error("wrong bank");
   property p_rel;
      @(posedge clk) disable iff (!resetn)
         (ce && !ack_n) |=> xcvr_oe_n && !host_data_oe;
   endproperty
   a_rel: assert property (p_rel) else $error("bus not released");
   property p_miss;
      @(posedge clk) disable iff (!resetn)
         (ce && !io_hit && !id_hit) |=> ack_n && xcvr_oe_n
         && first_quad_converter_cs_n && second_quad_converter_cs_n;
   endproperty
   a_miss: assert property (p_miss) else $error("miss acted");
   // ---------------------------------------------------------------
   // assertions: decode and data paths
   // ---------------------------------------------------------------
   property p_int_ign;
      @(posedge clk) disable iff (!resetn)
         (ce && st_q == S_IDLE && io_sel_n && id_sel_n
         && (!int_sel_n || !dma_ack_n)) |=> ack_n;
   endproperty
   a_int_ign: assert property (p_int_ign) else $error("int acked");
   property p_part;
      @(posedge clk) disable iff (!resetn)
         (ce && !io_sel_n && id_sel_n && addr[6:4] != 3'h0) |=> ack_n
         && first_quad_converter_cs_n && second_quad_converter_cs_n;
   endproperty
   a_part: assert property (p_part) else $error("partial io");
   property p_id_part;
      @(posedge clk) disable iff (!resetn)
         (ce && !id_sel_n && io_sel_n && addr[6])
         |=> ack_n && !host_data_oe;
   endproperty
   a_id_part: assert property (p_id_part) else $error("partial id");
   property p_wr_path;
      @(posedge clk) disable iff (!resetn)
         (ce && st_q == S_IDLE && io_hit && !hold && !rw_n && word_xfer)
         |=> !xcvr_oe_n && xcvr_dir_h2c && !conv_wr_n && !host_data_oe;
   endproperty
   a_wr_path: assert property (p_wr_path) else $error("write path");
   property p_rd_path;
      @(posedge clk) disable iff (!resetn)
         (ce && st_q == S_IDLE && io_hit && !hold && rw_n)
         |=> !xcvr_oe_n && !xcvr_dir_h2c && !conv_rd_n && host_data_oe;
   endproperty
   a_rd_path: assert property (p_rd_path) else $error("read path");
   property p_hi_bank;
      @(posedge clk) disable iff (!resetn)
         (ce && st_q == S_IDLE && io_hit && !hold && addr[3])
         |=> !second_quad_converter_cs_n && first_quad_converter_cs_n;
   endproperty
   a_hi_bank: assert property (p_hi_bank) else $error("high bank");
   property p_one_cs;
      @(posedge clk) disable iff (!resetn)
         first_quad_converter_cs_n || second_quad_converter_cs_n;
   endproperty
   a_one_cs: assert property (p_one_cs) else $error("both banks");
   property p_ack1;
      @(posedge clk) disable iff (!resetn)
         (ce && !ack_n) |=> ack_n;
   endproperty
   a_ack1: assert property (p_ack1) else $error("ack stuck");
   property p_top0;
      @(posedge clk) disable iff (!resetn)
         (ce && st_q == S_IDLE && io_hit && !hold && rw_n)
         |=> host_data_out[15:12] == 4'h0;
   endproperty
   a_top0: assert property (p_top0) else $error("read top bits");
   // ---------------------------------------------------------------
   // cover points
   // ---------------------------------------------------------------
   c_wr: cover property (@(posedge clk) disable iff (!resetn)
      !conv_wr_n && xcvr_dir_h2c);
   c_rd: cover property (@(posedge clk) disable iff (!resetn)
      !conv_rd_n && !second_quad_converter_cs_n);
   c_id: cover property (@(posedge clk) disable iff (!resetn)
      !ack_n && xcvr_oe_n && host_data_oe);
   c_hold: cover property (@(posedge clk) disable iff (!resetn)
      st_q == S_IDLE && io_hit && hold);
   c_hi: cover property (@(posedge clk) disable iff (!resetn)
      !second_quad_converter_cs_n && !conv_wr_n);
endmodule
`default_nettype wire

// *** ipx_id_rom.sv ***
// identification word pattern, emulated prom
// assumes a registered word index
`default_nettype none
module ipx_id_rom
   import ipx_pkg::*;
(
   // lookup
   input wire logic [4:0] idx,
   output logic [15:0] word
);
   always_comb begin
      unique case (idx)
         5'h00: word = 16'h0049;
         5'h01: word = 16'h0050;
         5'h02: word = 16'h0041;
         5'h03: word = 16'h0043;
         5'h04: word = {8'h00, ID_MAKER};
         5'h05: word = {8'h00, ID_MODEL};
         5'h06: word = {8'h00, ID_REV};
         5'h07: word = 16'h0000;
         5'h08: word = 16'h0000;
         5'h09: word = 16'h0000;
         5'h0a: word = 16'h0000;
         5'h0b: word = {8'h00, ID_LEN};
         default: word = 16'h0000;
      endcase
   end
endmodule
`default_nettype wire

// *** ipx_pkg.sv ***
// package for the ip module converter bus slave
// assumes a 25 mhz bus clock shared by all files
`default_nettype none
package ipx_pkg;
   // ---------------------------------------------------------------
   // address map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int CODE_W = 12;
   localparam int CHAN_N = 8;
   localparam int ID_WORDS = 32;
   localparam logic [5:0] IO_MASK = 6'h38;
   localparam logic [5:0] IO_BASE = 6'h00;
   localparam logic [5:0] ID_MASK = 6'h20;
   localparam logic [5:0] ID_BASE = 6'h00;
   localparam int BANK_BIT = 2;
   // ---------------------------------------------------------------
   // values after reset
   // ---------------------------------------------------------------
   localparam logic [11:0] MID_CODE = 12'h800;
   localparam logic [11:0] CODE_STEPS_M1 = 12'hfff;
   // identity values below are arbitrary
   localparam logic [7:0] ID_MAKER = 8'h5a;
   localparam logic [7:0] ID_MODEL = 8'h3c;
   localparam logic [7:0] ID_REV = 8'h01;
   localparam logic [7:0] ID_LEN = 8'h0c;
   // ---------------------------------------------------------------
   // bus limit: data release after the strobe ends
   // ---------------------------------------------------------------
   localparam int REL_NS = 40;
   localparam int CLK_NS = 40;
   localparam int REL_CYC = (REL_NS / CLK_NS < 1) ? 1 : REL_NS / CLK_NS;
endpackage
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the converter bus slave engine
// assumes ipx_carrier as bus master and a 25 mhz clock
`default_nettype none
module tb_top
   import ipx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, resetn;
   logic ce = 1'b1;
   logic io_sel_n, id_sel_n, mem_sel_n, int_sel_n, dma_ack_n;
   logic rw_n, be0_n, be1_n, hold, host_data_oe, ack_n;
   logic [ADDR_W:1] addr;
   logic [DATA_W-1:0] host_data_in, host_data_out;
   logic int_req0_n, int_req1_n, dma_req_n, xcvr_oe_n, xcvr_dir_h2c;
   logic first_cs_n, second_cs_n, conv_wr_n, conv_rd_n;
   logic [CHAN_N*CODE_W-1:0] dac_code;
   logic [6:0] snap = 7'h00;
   int act = 0;
   int cycles = 0;
   int miscompares = 0;
   int n_checks = 0;

   ipx_engine u_ipx_engine (.clk(clk), .resetn(resetn), .ce(ce),
      .io_sel_n(io_sel_n), .id_sel_n(id_sel_n), .mem_sel_n(mem_sel_n),
      .int_sel_n(int_sel_n), .dma_ack_n(dma_ack_n), .rw_n(rw_n),
      .be0_n(be0_n), .be1_n(be1_n), .hold(hold), .addr(addr),
      .host_data_in(host_data_in), .host_data_out(host_data_out),
      .host_data_oe(host_data_oe), .ack_n(ack_n),
      .int_req0_n(int_req0_n), .int_req1_n(int_req1_n),
      .dma_req_n(dma_req_n), .xcvr_oe_n(xcvr_oe_n),
      .xcvr_dir_h2c(xcvr_dir_h2c), .first_quad_converter_cs_n(first_cs_n),
      .second_quad_converter_cs_n(second_cs_n), .conv_wr_n(conv_wr_n),
      .conv_rd_n(conv_rd_n), .dac_code(dac_code));

   ipx_carrier u_ipx_carrier (.clk(clk), .io_sel_n(io_sel_n),
      .id_sel_n(id_sel_n), .mem_sel_n(mem_sel_n), .int_sel_n(int_sel_n),
      .dma_ack_n(dma_ack_n), .rw_n(rw_n), .be0_n(be0_n), .be1_n(be1_n),
      .hold(hold), .addr(addr), .host_data_in(host_data_in),
      .ack_n(ack_n), .host_data_out(host_data_out));

   // ---------------------------------------------------------------
   // clock, ack-cycle snapshot, activity, timeout
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(negedge clk) begin
      if (ack_n === 1'b0) snap = {first_cs_n, second_cs_n, conv_wr_n,
         conv_rd_n, xcvr_oe_n, xcvr_dir_h2c, host_data_oe};
      if (resetn && {ack_n, first_cs_n, second_cs_n, xcvr_oe_n,
         conv_wr_n, conv_rd_n} !== 6'h3f) act++;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   function automatic logic [11:0] code_of(input int k);
      return (k == 7) ? 12'hfff : 12'(k * 12'h123);
   endfunction
   task automatic print_verdict();
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      for (int k = 0; k < 8; k++) begin
         chk(16'(dac_code[12*k +: 12]), 16'(MID_CODE));
      end
      chk(16'({conv_wr_n, conv_rd_n, host_data_oe}), 16'h0006);
      chk(16'({ack_n, first_cs_n, second_cs_n, xcvr_oe_n}), 16'h000f);
   endtask
   // all eight channels, 0 and full scale at the ends
   task automatic t_write();
      int lat;
      logic [15:0] rd;
      for (int k = 0; k < 8; k++) begin
         u_ipx_carrier.cyc(0, 1'b0, 2'b00, 6'(k), {4'ha, code_of(k)}, 0,
            lat, rd);
         chk(16'(lat), 16'h0001);
         // {cs1,cs2,wr,rd,oe_n,dir,oe}
         chk(16'(snap), (k < 4) ? 16'h002a : 16'h004a);
      end
      for (int k = 0; k < 8; k++) begin
         chk(16'(dac_code[12*k +: 12]), 16'(code_of(k)));
      end
   endtask
   task automatic t_read();
      int lat;
      int h;
      logic [15:0] rd;
      for (int k = 0; k < 8; k++) begin
         h = (k == 5) ? 3 : 0;
         u_ipx_carrier.cyc(0, 1'b1, 2'b00, 6'(k), 16'h5a5a, h, lat, rd);
         chk(16'(lat), 16'(h + 1));
         chk(rd, 16'(code_of(k)));
         chk(16'(snap), (k < 4) ? 16'h0031 : 16'h0051);
         chk(16'({xcvr_oe_n, host_data_oe}), 16'h0002);
      end
   endtask
   // byte write is acked but must not reach the converter
   task automatic t_byte();
      int lat;
      logic [15:0] rd;
      u_ipx_carrier.cyc(0, 1'b0, 2'b10, 6'h00, 16'h0abc, 2, lat, rd);
      chk(16'(lat), 16'h0003);
      chk(16'(snap[4:2]), 16'h0007);
      chk(16'(dac_code[11:0]), 16'(code_of(0)));
   endtask
   // clock enable low freezes the engine: no ack, code kept
   task automatic t_freeze();
      int lat;
      logic [15:0] rd;
      @(posedge clk);
      ce <= 1'b0;
      u_ipx_carrier.cyc(0, 1'b0, 2'b00, 6'h00, 16'h0abc, 0, lat, rd);
      @(posedge clk);
      ce <= 1'b1;
      chk(16'(lat), 16'h0000);
      chk(16'(dac_code[11:0]), 16'(code_of(0)));
   endtask
   task automatic t_id();
      int lat;
      logic [15:0] rd;
      int ix[9] = '{0, 1, 2, 3, 4, 5, 6, 11, 31};
      logic [15:0] ev[9] = '{16'h0049, 16'h0050, 16'h0041, 16'h0043,
         {8'h00, ID_MAKER}, {8'h00, ID_MODEL}, {8'h00, ID_REV},
         {8'h00, ID_LEN}, 16'h0000};
      for (int i = 0; i < 9; i++) begin
         u_ipx_carrier.cyc(1, 1'b1, 2'b00, 6'(ix[i]), 16'h0, 0, lat, rd);
         chk(16'(lat), 16'h0001);
         chk(rd, ev[i]);
         chk(16'({snap[6:2], snap[0]}), 16'h003f);
      end
   endtask
   // partial decodes and unsupported cycle kinds
   task automatic t_miss();
      int lat;
      logic [15:0] rd;
      int kd[7] = '{0, 0, 0, 1, 2, 3, 4};
      logic [5:0] ad[7] = '{6'h08, 6'h10, 6'h20, 6'h20, 6'h00, 6'h00,
         6'h00};
      act = 0;
      for (int i = 0; i < 7; i++) begin
         u_ipx_carrier.cyc(kd[i], i[0], 2'b00, ad[i], 16'h1234, 0, lat, rd);
         chk(16'(lat), 16'h0000);
      end
      chk(16'(act), 16'h0000);
      chk(16'({int_req0_n, int_req1_n, dma_req_n}), 16'h0007);
   endtask

   initial begin
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      t_reset();
      @(posedge clk);
      resetn <= 1'b1;
      t_write();
      t_read();
      t_byte();
      t_freeze();
      t_id();
      t_miss();
      print_verdict();
   end
endmodule
`default_nettype wire
